/* File: rtl/uart_flag_consts.vh */
/*
 * Constants for the uart status-flag block: register byte offsets,
 * field positions, reset values and idle-detect bit counts.
 * Assumes a 32-bit AHB-Lite bus with one register per aligned word.
 */
`ifndef UART_FLAG_CONSTS_VH
`define UART_FLAG_CONSTS_VH

// ************************************************
// register byte offsets
// ************************************************
`define OFF_CONTROL_ONE 8'h00
`define OFF_CONTROL_TWO 8'h04
`define OFF_STATUS_ONE 8'h08
`define OFF_CONTROL_THREE 8'h0c
`define OFF_DATA 8'h10

// ************************************************
// field positions
// ************************************************
`define C1_NINE_BIT 4
`define C1_IDLE_SEL 2
`define C1_PARITY_EN 1
`define C2_RX_IRQ_EN 5
`define C2_TX_EN 3
`define C2_SEND_BREAK 0
`define C3_RX_NINTH 7
`define S1_TX_BUFFER_EMPTY_FLAG 7
`define S1_TC 6
`define S1_RX_BUFFER_FULL_FLAG 5
`define S1_IDLE 4
`define S1_OR 3
`define S1_NF 2
`define S1_FE 1
`define S1_PF 0

// ************************************************
// reset values and idle counts
// ************************************************
`define STATUS_RESET 8'hc0
`define CONTROL_RESET 8'h00
`define IDLE_BITS_EIGHT 4'ha
`define IDLE_BITS_NINE 4'hb

`endif

/* File: rtl/uart_status_flag_logic.v */
/*
 * Status-flag logic of a uart: eight read-only flags, their set events
 * and their read-then-access clearing sequences, behind an AHB-Lite
 * register slave.
 * Assumes the shifters, baud generator and sampler live outside and
 * report through one-cycle strobes synchronous to hclk; every bus
 * access is a single whole-word transfer.
 */
`include "uart_flag_consts.vh"
`default_nettype none

module uart_status_flag_logic (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire tx_load_strobe,
  input wire tx_busy,
  input wire rx_char_strobe,
  input wire [8:0] rx_char_data,
  input wire rx_noise,
  input wire rx_stop_low,
  input wire rx_parity_mismatch,
  input wire rx_bit_tick,
  input wire rx_line,
  input wire rx_start_end,
  input wire rx_stop_end,
  output reg [7:0] tx_data,
  output reg tx_data_valid,
  output reg preamble_request,
  output reg send_break_bit,
  output reg tx_enable,
  output reg nine_bit_mode,
  output reg idle_count_select,
  output reg parity_enable,
  output reg rx_full_irq
);

  // ************************************************
  // helpers
  // ************************************************
  function hit;
    input [31:0] addr;
    input [7:0] off;
    begin
      hit = (addr[31:8] == 24'h000000) && (addr[7:0] == off);
    end
  endfunction

  // ************************************************
  // bus address and data phase
  // ************************************************
  wire addr_take;
  wire rd_take;
  reg wr_pend_reg;
  reg [31:0] wr_addr_reg;
  wire wr_data;
  wire rd_status;
  wire rd_data;
  wire rd_c3;
  wire wr_c1;
  wire wr_c2;
  wire wr_dreg;

  // hsize is not checked: only whole-word transfers are expected
  assign addr_take = hsel && htrans[1] && hready;
  assign rd_take = addr_take && !hwrite;
  assign wr_data = wr_pend_reg;
  assign rd_status = rd_take && hit(haddr, `OFF_STATUS_ONE);
  assign rd_data = rd_take && hit(haddr, `OFF_DATA);
  assign rd_c3 = rd_take && hit(haddr, `OFF_CONTROL_THREE);
  assign wr_c1 = wr_data && hit(wr_addr_reg, `OFF_CONTROL_ONE);
  assign wr_c2 = wr_data && hit(wr_addr_reg, `OFF_CONTROL_TWO);
  assign wr_dreg = wr_data && hit(wr_addr_reg, `OFF_DATA);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_reg <= addr_take && hwrite;
      if (addr_take && hwrite) begin
        wr_addr_reg <= haddr;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ************************************************
  // flag state
  // ************************************************
  reg tx_buffer_empty_flag_reg;
  reg tc_reg;
  reg rx_buffer_full_flag_reg;
  reg idle_reg;
  reg or_reg;
  reg nf_reg;
  reg fe_reg;
  reg pf_reg;
  reg [7:0] arm_reg;
  reg rd_d_seen_reg;
  reg rd_c3_seen_reg;
  reg [7:0] rx_data_reg;
  reg rx_ninth_bit;
  reg rx_full_irq_enable;
  wire [7:0] status_now;
  wire rx_accept;
  wire rx_overrun;
  wire te_rise;
  wire sbk_write;
  wire idle_hit;
  wire rx_buffer_full_flag_clear;
  wire d_done;
  wire c3_done;

  assign status_now = {tx_buffer_empty_flag_reg, tc_reg, rx_buffer_full_flag_reg, idle_reg,
                       or_reg, nf_reg, fe_reg, pf_reg};
  assign rx_accept = rx_char_strobe && !rx_buffer_full_flag_reg;
  assign rx_overrun = rx_char_strobe && rx_buffer_full_flag_reg;
  assign te_rise = wr_c2 && hwdata[`C2_TX_EN] && !tx_enable;
  assign sbk_write = wr_c2 && hwdata[`C2_SEND_BREAK];
  assign d_done = rd_data || rd_d_seen_reg;
  assign c3_done = rd_c3 || rd_c3_seen_reg;
  assign rx_buffer_full_flag_clear = arm_reg[`S1_RX_BUFFER_FULL_FLAG] &&
                      (nine_bit_mode ? (d_done && c3_done) : rd_data);

  // ************************************************
  // flag set and clear; a set in the same cycle wins, except for tc, whose clear wins
  // ************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_buffer_empty_flag_reg <= 1'b1;
      tc_reg <= 1'b1;
      rx_buffer_full_flag_reg <= 1'b0;
      idle_reg <= 1'b0;
      or_reg <= 1'b0;
      nf_reg <= 1'b0;
      fe_reg <= 1'b0;
      pf_reg <= 1'b0;
    end else begin
      if (tx_load_strobe) begin
        tx_buffer_empty_flag_reg <= 1'b1;
      end else if (wr_dreg && arm_reg[`S1_TX_BUFFER_EMPTY_FLAG]) begin
        tx_buffer_empty_flag_reg <= 1'b0;
      end
      // a queuing write is activity already, or the set would beat its clear
      // quiet transmitter
      if (tx_buffer_empty_flag_reg && !tx_busy && !preamble_request && !send_break_bit &&
          !wr_dreg && !te_rise && !sbk_write) begin
        tc_reg <= 1'b1;
      end else if (arm_reg[`S1_TC] && (wr_dreg || te_rise || sbk_write)) begin
        tc_reg <= 1'b0;
      end
      if (rx_accept) begin
        rx_buffer_full_flag_reg <= 1'b1;
      end else if (rx_buffer_full_flag_clear) begin
        rx_buffer_full_flag_reg <= 1'b0;
      end
      if (idle_hit) begin
        idle_reg <= 1'b1;
      end else if (arm_reg[`S1_IDLE] && rd_data) begin
        idle_reg <= 1'b0;
      end
      if (rx_overrun) begin
        or_reg <= 1'b1;
      end else if (arm_reg[`S1_OR] && rd_data) begin
        or_reg <= 1'b0;
      end
      if (rx_accept && rx_noise) begin
        nf_reg <= 1'b1;
      end else if (arm_reg[`S1_NF] && rd_data) begin
        nf_reg <= 1'b0;
      end
      if (rx_accept && rx_stop_low) begin
        fe_reg <= 1'b1;
      end else if (arm_reg[`S1_FE] && rd_data) begin
        fe_reg <= 1'b0;
      end
      if (rx_accept && parity_enable && rx_parity_mismatch) begin
        pf_reg <= 1'b1;
      end else if (arm_reg[`S1_PF] && rd_data) begin
        pf_reg <= 1'b0;
      end
    end
  end

  // ************************************************
  // clear arming
  // ************************************************
  reg [7:0] set_ev;
  reg [7:0] done_ev;

  always @* begin
    set_ev = 8'h00;
    set_ev[`S1_TX_BUFFER_EMPTY_FLAG] = tx_load_strobe;
    set_ev[`S1_TC] = !tc_reg;
    set_ev[`S1_RX_BUFFER_FULL_FLAG] = rx_accept;
    set_ev[`S1_IDLE] = idle_hit;
    set_ev[`S1_OR] = rx_overrun;
    set_ev[`S1_NF] = rx_accept && rx_noise;
    set_ev[`S1_FE] = rx_accept && rx_stop_low;
    set_ev[`S1_PF] = rx_accept && rx_parity_mismatch;
    done_ev = 8'h00;
    done_ev[`S1_TX_BUFFER_EMPTY_FLAG] = wr_dreg;
    done_ev[`S1_TC] = wr_dreg || te_rise || sbk_write;
    done_ev[`S1_RX_BUFFER_FULL_FLAG] = rx_buffer_full_flag_clear;
    done_ev[`S1_IDLE] = rd_data;
    done_ev[`S1_OR] = rd_data;
    done_ev[`S1_NF] = rd_data;
    done_ev[`S1_FE] = rd_data;
    done_ev[`S1_PF] = rd_data;
  end

  // arm on status read, disarm on new set
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_reg <= 8'h00;
      rd_d_seen_reg <= 1'b0;
      rd_c3_seen_reg <= 1'b0;
    end else begin
      if (rd_status) begin
        // noise and parity arm without seeing a set flag
        arm_reg <= (status_now | 8'h05) & ~set_ev;
      end else begin
        arm_reg <= arm_reg & ~set_ev & ~done_ev;
      end
      if (rd_status || rx_accept || rx_buffer_full_flag_clear) begin
        rd_d_seen_reg <= 1'b0;
        rd_c3_seen_reg <= 1'b0;
      end else if (arm_reg[`S1_RX_BUFFER_FULL_FLAG]) begin
        rd_d_seen_reg <= d_done;
        rd_c3_seen_reg <= c3_done;
      end
    end
  end

  // ************************************************
  // idle line detection
  // ************************************************
  reg idle_armed_reg;
  reg counting_reg;
  reg [3:0] idle_cnt_reg;
  wire [3:0] idle_need;
  wire [3:0] idle_cnt_next;

  assign idle_need = nine_bit_mode ? `IDLE_BITS_NINE : `IDLE_BITS_EIGHT;
  assign idle_cnt_next = rx_line ? (idle_cnt_reg + 4'h1) : 4'h0;
  assign idle_hit = counting_reg && idle_armed_reg && rx_bit_tick &&
                    (idle_cnt_next == idle_need);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_armed_reg <= 1'b0;
      counting_reg <= 1'b0;
      idle_cnt_reg <= 4'h0;
    end else begin
      if (rx_accept) begin
        idle_armed_reg <= 1'b1;
      end else if (idle_hit) begin
        idle_armed_reg <= 1'b0;
      end
      // count from end of start bit
      if (rx_start_end) begin
        counting_reg <= !idle_count_select;
        idle_cnt_reg <= 4'h0;
      // count from end of stop bit
      end else if (rx_stop_end && idle_count_select) begin
        counting_reg <= 1'b1;
        idle_cnt_reg <= 4'h0;
      end else if (idle_hit) begin
        counting_reg <= 1'b0;
        idle_cnt_reg <= 4'h0;
      end else if (counting_reg && rx_bit_tick) begin
        idle_cnt_reg <= idle_cnt_next;
      end
    end
  end

  // ************************************************
  // receive data and control registers
  // ************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_data_reg <= 8'h00;
      rx_ninth_bit <= 1'b0;
      nine_bit_mode <= 1'b0;
      idle_count_select <= 1'b0;
      parity_enable <= 1'b0;
      rx_full_irq_enable <= 1'b0;
      tx_enable <= 1'b0;
      send_break_bit <= 1'b0;
      preamble_request <= 1'b0;
      tx_data <= 8'h00;
      tx_data_valid <= 1'b0;
      rx_full_irq <= 1'b0;
    end else begin
      // the new character is dropped on overrun
      if (rx_accept) begin
        rx_data_reg <= rx_char_data[7:0];
        // ninth bit kept for control three
        rx_ninth_bit <= rx_char_data[8];
      end
      if (wr_c1) begin
        nine_bit_mode <= hwdata[`C1_NINE_BIT];
        idle_count_select <= hwdata[`C1_IDLE_SEL];
        parity_enable <= hwdata[`C1_PARITY_EN];
      end
      if (wr_c2) begin
        rx_full_irq_enable <= hwdata[`C2_RX_IRQ_EN];
        tx_enable <= hwdata[`C2_TX_EN];
        send_break_bit <= hwdata[`C2_SEND_BREAK];
      end
      // held until the transmitter starts, so completion stays low
      if (te_rise) begin
        preamble_request <= 1'b1;
      end else if (tx_busy) begin
        preamble_request <= 1'b0;
      end
      if (wr_dreg) begin
        tx_data <= hwdata[7:0];
        tx_data_valid <= 1'b1;
      end else if (tx_load_strobe) begin
        tx_data_valid <= 1'b0;
      end
      rx_full_irq <= rx_full_irq_enable &&
                     (rx_accept || (rx_buffer_full_flag_reg && !rx_buffer_full_flag_clear));
    end
  end

  // ************************************************
  // read data, captured at address acceptance
  // ************************************************
  reg [31:0] rd_value;

  always @* begin
    rd_value = 32'h00000000;
    if (hit(haddr, `OFF_CONTROL_ONE)) begin
      rd_value[`C1_NINE_BIT] = nine_bit_mode;
      rd_value[`C1_IDLE_SEL] = idle_count_select;
      rd_value[`C1_PARITY_EN] = parity_enable;
    end else if (hit(haddr, `OFF_CONTROL_TWO)) begin
      rd_value[`C2_RX_IRQ_EN] = rx_full_irq_enable;
      rd_value[`C2_TX_EN] = tx_enable;
      rd_value[`C2_SEND_BREAK] = send_break_bit;
    end else if (hit(haddr, `OFF_STATUS_ONE)) begin
      rd_value[7:0] = status_now;
    end else if (hit(haddr, `OFF_CONTROL_THREE)) begin
      rd_value[`C3_RX_NINTH] = rx_ninth_bit;
    end else if (hit(haddr, `OFF_DATA)) begin
      rd_value[7:0] = rx_data_reg;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_take) begin
      hrdata <= rd_value;
    end
  end

endmodule // uart_status_flag_logic

`default_nettype wire

/* File: verification/uart_flag_properties.sv */
/* Property checker for the uart status flags, bound into the block.
   Assumes whole-word AHB-Lite transfers with zero wait states. */
`include "uart_flag_consts.vh"
`default_nettype none
module uart_flag_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic tx_load_strobe,
  input wire logic tx_busy,
  input wire logic [7:0] tx_data,
  input wire logic tx_data_valid,
  input wire logic preamble_request,
  input wire logic send_break_bit,
  input wire logic tx_enable,
  input wire logic nine_bit_mode,
  input wire logic idle_count_select,
  input wire logic parity_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph_v_reg, ph_w_reg, dwr, c1w, c2w, rd_go;
  logic [7:0] ph_a_reg, wd_reg;
  // ****************
  // data-phase tracking
  // ****************
  // write effects land at the data-phase edge, so the address is kept
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ph_v_reg, ph_w_reg, ph_a_reg, wd_reg} <= '0;
    end else begin
      ph_v_reg <= rd_go || (hsel && htrans[1] && hready);
      {ph_w_reg, ph_a_reg, wd_reg} <= {hwrite, haddr[7:0], hwdata[7:0]};
    end
  end
  assign rd_go = hsel && htrans[1] && hready && !hwrite;
  assign dwr = ph_v_reg && ph_w_reg && ph_a_reg == `OFF_DATA;
  assign c1w = ph_v_reg && ph_w_reg && ph_a_reg == `OFF_CONTROL_ONE;
  assign c2w = ph_v_reg && ph_w_reg && ph_a_reg == `OFF_CONTROL_TWO;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_always_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_status_upper_zero: assert property (rd_go && haddr == 32'h08 |=>
    hrdata[31:8] == 24'h0) else $error("status read has upper bits");
  a_unmapped_reads_zero: assert property (rd_go && haddr == 32'h14 |=>
    hrdata == 32'h0) else $error("unmapped read not zero");
  a_data_write_loads: assert property (dwr |=> tx_data_valid &&
    tx_data == wd_reg) else $error("data write not taken");
  a_load_drains_buffer: assert property (tx_load_strobe && !dwr |=>
    !tx_data_valid) else $error("buffer still full after load");
  a_valid_needs_write: assert property ($rose(tx_data_valid) |->
    $past(dwr)) else $error("buffer filled without data write");
  a_ctrl_two_write: assert property (c2w |=> tx_enable == wd_reg[3] &&
    send_break_bit == wd_reg[0]) else $error("control two not taken");
  a_enable_rise_preamble: assert property (c2w && hwdata[3] &&
    !tx_enable && !tx_busy |=> preamble_request) else $error("no preamble");
  a_ctrl_one_write: assert property (c1w |=> nine_bit_mode == wd_reg[4]
    && idle_count_select == wd_reg[2] && parity_enable == wd_reg[1])
    else $error("control one not taken");
  c_data_write: cover property (dwr);
  c_buffer_load: cover property (tx_load_strobe);
  c_preamble: cover property (preamble_request);
endmodule // uart_flag_properties
bind uart_status_flag_logic uart_flag_properties chk (.*);
`default_nettype wire

/* File: verification/serial_far_end.sv */
/* Far-side model: transmit shifter timing and receive framing strobes.
   Assumes its tasks are called just after a rising edge of hclk. */
`default_nettype none
module serial_far_end (
  input wire logic hclk,
  input wire logic tx_stall,
  input wire logic tx_data_valid,
  input wire logic preamble_request,
  output logic tx_load_strobe,
  output logic tx_busy,
  output logic rx_char_strobe,
  output logic [8:0] rx_char_data,
  output logic rx_noise,
  output logic rx_stop_low,
  output logic rx_parity_mismatch,
  output logic rx_bit_tick,
  output logic rx_line,
  output logic rx_start_end,
  output logic rx_stop_end
);
  timeunit 1ns;
  timeprecision 1ps;
  int left_reg = 0;
  initial begin
    {tx_load_strobe, tx_busy, rx_char_strobe, rx_char_data} = '0;
    {rx_noise, rx_stop_low, rx_parity_mismatch, rx_bit_tick} = '0;
    {rx_start_end, rx_stop_end, rx_line} = 3'b001;
  end
  // ****************
  // transmitter and receiver
  // ****************
  // shifter takes the buffer, stays busy for a frame
  always @(posedge hclk) begin
    tx_load_strobe <= 1'b0;
    if (tx_busy) begin
      left_reg <= left_reg - 1;
      tx_busy <= left_reg > 1;
    end else if (preamble_request || (tx_data_valid && !tx_stall)) begin
      tx_load_strobe <= tx_data_valid && !tx_stall;
      tx_busy <= 1'b1;
      left_reg <= 20;
    end
  end
  task automatic tick(input logic v, input int n);
    repeat (n) begin
      rx_line <= v;
      rx_bit_tick <= 1'b1;
      @(posedge hclk);
      rx_bit_tick <= 1'b0;
      @(posedge hclk);
    end
  endtask
  // character hand-over with its error status
  task automatic frame(input logic [8:0] d, input logic nine,
                       input logic [2:0] err);
    {rx_line, rx_start_end} <= 2'b01;
    @(posedge hclk);
    rx_start_end <= 1'b0;
    for (int i = 0; i < (nine ? 9 : 8); i++) tick(d[i], 1);
    tick(!err[1], 1);
    {rx_noise, rx_stop_low, rx_parity_mismatch, rx_char_data} <= {err, d};
    {rx_stop_end, rx_char_strobe} <= 2'b11;
    @(posedge hclk);
    // levels only mean something with the strobe, so scramble them after
    {rx_noise, rx_stop_low, rx_parity_mismatch, rx_char_data} <= ~{err, d};
    {rx_stop_end, rx_char_strobe} <= 2'b00;
  endtask
endmodule // serial_far_end
`default_nettype wire

/* File: verification/uart_status_flag_logic_tb.sv */
/* Self-checking bench for the uart status flags: bus tasks, scenarios.
   Assumes the far-side model and the bound property checker. */
`include "uart_flag_consts.vh"
`default_nettype none
module uart_status_flag_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] st = `OFF_STATUS_ONE;
  localparam logic [7:0] da = `OFF_DATA;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_stall;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic tx_load_strobe, tx_busy, rx_char_strobe, rx_noise, rx_stop_low;
  logic rx_parity_mismatch, rx_bit_tick, rx_line, rx_start_end;
  logic rx_stop_end, tx_data_valid, preamble_request, rx_full_irq;
  logic [8:0] rx_char_data;
  int n_mismatch = 0;
  int num_checks = 0;
  uart_status_flag_logic DUT (.*, .hready(hreadyout), .tx_data(),
    .send_break_bit(), .tx_enable(), .nine_bit_mode(),
    .idle_count_select(), .parity_enable());
  serial_far_end far (.*);
  // ****************
  // clock, bus and checking tasks
  // ****************
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] wd, output logic [31:0] rd);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, 24'h0, a, w};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, 24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(r, {24'h0, e});
  endtask
  // the request output changes on the same edge as the flag
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge hclk);
    chk({31'h0, rx_full_irq}, {31'h0, e});
  endtask
  task automatic quiet;
    do @(posedge hclk);
    while ((tx_busy | tx_data_valid | preamble_request) !== 1'b0);
    @(posedge hclk);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    rd_chk(st, `STATUS_RESET);
    wr(st, 8'h00);
    rd_chk(st, `STATUS_RESET);
    rd_chk(8'h14, 8'h00);
  endtask
  task automatic t_tx;
    tx_stall <= 1'b1;
    rd_chk(st, 8'hc0);
    wr(da, 8'h5a);
    rd_chk(st, 8'h00);
    tx_stall <= 1'b0;
    do @(posedge hclk); while (tx_load_strobe !== 1'b1);
    rd_chk(st, 8'h80);
    quiet;
    rd_chk(st, 8'hc0);
    wr(`OFF_CONTROL_TWO, 8'h01);
    rd_chk(st, 8'h80);
    wr(`OFF_CONTROL_TWO, 8'h00);
    quiet;
    rd_chk(st, 8'hc0);
    wr(`OFF_CONTROL_TWO, 8'h08);
    rd_chk(st, 8'h80);
    quiet;
    rd_chk(st, 8'hc0);
  endtask
  task automatic t_idle;
    for (int s = 0; s < 2; s++) begin
      wr(`OFF_CONTROL_ONE, s ? 8'h04 : 8'h00);
      far.frame(9'h0ff, 1'b0, 3'b000);
      far.tick(1'b1, s ? 9 : 0);
      rd_chk(st, 8'he0);
      far.tick(1'b1, 1);
      rd_chk(st, 8'hf0);
      rd_chk(da, 8'hff);
      rd_chk(st, 8'hc0);
      far.tick(1'b1, 12);
      rd_chk(st, 8'hc0);
    end
  endtask
  task automatic t_err;
    wr(`OFF_CONTROL_ONE, 8'h02);
    far.frame(9'h033, 1'b0, 3'b111);
    rd_chk(st, 8'he7);
    far.frame(9'h044, 1'b0, 3'b000);
    rd_chk(st, 8'hef);
    rd_chk(da, 8'h33);
    rd_chk(st, 8'hc0);
  endtask
  task automatic t_nine;
    wr(`OFF_CONTROL_ONE, 8'h10);
    wr(`OFF_CONTROL_TWO, 8'h20);
    // parity mismatch with parity off must not raise the parity flag
    far.frame(9'h1a5, 1'b1, 3'b001);
    rd_chk(st, 8'he0);
    rd_chk(da, 8'ha5);
    irq_chk(1'b1);
    rd_chk(`OFF_CONTROL_THREE, 8'h80);
    irq_chk(1'b0);
    rd_chk(st, 8'hc0);
    // the two reads in the other order
    far.frame(9'h0c3, 1'b1, 3'b000);
    rd_chk(st, 8'he0);
    rd_chk(`OFF_CONTROL_THREE, 8'h00);
    irq_chk(1'b1);
    rd_chk(da, 8'hc3);
    irq_chk(1'b0);
    rd_chk(st, 8'hc0);
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, tx_stall, htrans} = '0;
    {haddr, hwdata, hsize} = {64'h0, 3'b010};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_tx;
    t_idle;
    t_err;
    t_nine;
    wrap_up;
  end
  // the whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    wrap_up;
  end
endmodule // uart_status_flag_logic_tb
`default_nettype wire
